// *** design/mcr_master_config.sv ***
// Master configuration register one with transmit block outputs.
`timescale 1ns/1ps
`default_nettype none
module mcr_master_config
  import mcr_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [MCR_ADDR_W-1:0] addr_in,
  input wire logic [MCR_DATA_W-1:0] wdata_in,
  input wire logic monitor_soft_reset_in,
  input wire logic remote_terminal_soft_reset_in,
  input wire logic bus_a_transmit_block_in,
  input wire logic bus_b_transmit_block_in,
  output logic [MCR_DATA_W-1:0] rdata_out,
  output logic [MCR_DATA_W-1:0] config_out,
  output logic [1:0] pointer_select_out,
  output logic bus_a_transmit_block_out,
  output logic bus_b_transmit_block_out
);
  typedef struct packed {
    logic [MCR_DATA_W-1:0] cfg;
    logic [MCR_DATA_W-1:0] rdata;
  } mcr_state_t;

  mcr_state_t st_r;
  mcr_state_t st_nxt;
  logic hit;
  logic block_a_bit;
  logic block_b_bit;

  // True when the word address selects configuration register one
  function automatic logic mcr_is_cfg1(input logic [MCR_ADDR_W-1:0] addr);
    return (addr == MCR_CFG1_OFFSET);
  endfunction

  // Clears the bits that hold no state, so reserved bits never store or read back
  function automatic logic [MCR_DATA_W-1:0] mcr_keep_bits(input logic [MCR_DATA_W-1:0] word);
    return word & MCR_CFG1_MASK;
  endfunction

  // Address decode, shared by the next-state logic and the checks
  assign hit = mcr_is_cfg1(addr_in);

  // Register bits that feed the two transmit block combiners
  assign block_a_bit = st_r.cfg[MCR_BIT_BLOCK_A];
  assign block_b_bit = st_r.cfg[MCR_BIT_BLOCK_B];

  // Next state: only host writes change the register, soft resets are not inputs to it
  always_comb begin
    st_nxt = st_r;
    if (wr_en_in && hit) begin
      st_nxt.cfg = mcr_keep_bits(wdata_in);
    end
    if (rd_en_in) begin
      st_nxt.rdata = hit ? mcr_keep_bits(st_r.cfg) : MCR_READ_UNMAPPED;
    end
  end

  // Register the state; master reset clears everything
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_r <= '{cfg: MCR_CFG1_RESET, rdata: MCR_READ_UNMAPPED};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata_out = st_r.rdata;
  assign config_out = st_r.cfg;
  assign pointer_select_out = st_r.cfg[MCR_PTR_LSB+1:MCR_PTR_LSB];

  // Bus A block
  mcr_block_or u_block_a (
    .reg_bit_in(block_a_bit),
    .pin_in(bus_a_transmit_block_in),
    .block_out(bus_a_transmit_block_out)
  );

  // Bus B block
  mcr_block_or u_block_b (
    .reg_bit_in(block_b_bit),
    .pin_in(bus_b_transmit_block_in),
    .block_out(bus_b_transmit_block_out)
  );

  // Checks: all but the reset and pin ones rest while the master reset is held

  // A write to the mapped word lands on the next edge, reserved bits dropped
  a_write_stores: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (wr_en_in && hit)
    |=> (config_out == ($past(wdata_in) & MCR_CFG1_MASK)))
    else $error("write not stored");

  // Without a write to the mapped word the register keeps its value
  a_hold_no_write: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    !(wr_en_in && hit)
    |=> $stable(config_out))
    else $error("register changed without write");

  // Soft-reset requests of the terminals leave the register alone
  a_soft_reset_keep: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    ((monitor_soft_reset_in || remote_terminal_soft_reset_in) && !wr_en_in)
    |=> $stable(config_out))
    else $error("soft reset changed register");

  // Unused bits never hold a one, neither stored nor read back
  a_reserved_zero: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (config_out[13:12] == 2'h0) && (rdata_out[13:12] == 2'h0))
    else $error("reserved bits not zero");

  // Bus A block follows its register bit or its pin
  a_block_a_or: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    bus_a_transmit_block_out == (config_out[15] | bus_a_transmit_block_in))
    else $error("bus A block wrong");

  // Bus B block follows its register bit or its pin
  a_block_b_or: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    bus_b_transmit_block_out == (config_out[14] | bus_b_transmit_block_in))
    else $error("bus B block wrong");

  // A read of the mapped word returns the register one edge later
  a_read_data: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (rd_en_in && hit && !wr_en_in)
    |=> (rdata_out == config_out))
    else $error("read data wrong");

  // The pointer-select field takes the written bits
  a_pointer_field: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (wr_en_in && hit)
    |=> (pointer_select_out == $past(wdata_in[11:10])))
    else $error("pointer select wrong");

  // Master reset holds the register at zero without a clock
  a_reset_clear: assert property (
    @(posedge clk_sys_in)
    !arst_n_in |-> (config_out == 16'h0000))
    else $error("reset did not clear");

  // Reads of any other address return the unmapped value
  a_unmapped_read: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (rd_en_in && !hit)
    |=> (rdata_out == MCR_READ_UNMAPPED))
    else $error("unmapped read not zero");

  // Writes to any other address leave the register alone
  a_unmapped_write: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (wr_en_in && !hit)
    |=> $stable(config_out))
    else $error("unmapped write changed register");

  // Read data stands until the next read
  a_read_hold: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    !rd_en_in
    |=> $stable(rdata_out))
    else $error("read data changed without read");

  // Data written is what a later read of the word returns
  a_write_read_back: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (wr_en_in && hit) ##1 !(wr_en_in && hit) ##1 (rd_en_in && hit && !wr_en_in)
    |=> (rdata_out == ($past(wdata_in, 3) & MCR_CFG1_MASK)))
    else $error("read back differs from write");

  // The low ten bits are plain storage
  a_low_bits_store: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (wr_en_in && hit)
    |=> (config_out[MCR_PTR_LSB-1:0] == $past(wdata_in[MCR_PTR_LSB-1:0])))
    else $error("low bits not stored");

  // The bus A block bit takes the written bit
  a_block_a_store: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (wr_en_in && hit)
    |=> (config_out[MCR_BIT_BLOCK_A] == $past(wdata_in[MCR_BIT_BLOCK_A])))
    else $error("bus A block bit not stored");

  // The bus B block bit takes the written bit
  a_block_b_store: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (wr_en_in && hit)
    |=> (config_out[MCR_BIT_BLOCK_B] == $past(wdata_in[MCR_BIT_BLOCK_B])))
    else $error("bus B block bit not stored");

  // The pointer-select field moves only on a write
  a_pointer_hold: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    !(wr_en_in && hit)
    |=> $stable(pointer_select_out))
    else $error("pointer select changed without write");

  // Master reset clears the read data and the pointer field too
  a_reset_outputs: assert property (
    @(posedge clk_sys_in)
    !arst_n_in |-> ((rdata_out == MCR_READ_UNMAPPED) && (pointer_select_out == 2'h0)))
    else $error("reset left outputs set");

  // While reset is held only the pins block the buses
  a_reset_pins_only: assert property (
    @(posedge clk_sys_in)
    !arst_n_in |-> ((bus_a_transmit_block_out == bus_a_transmit_block_in)
      && (bus_b_transmit_block_out == bus_b_transmit_block_in)))
    else $error("block outputs wrong in reset");

  // A pin alone blocks its bus whatever the register holds
  a_pins_block: assert property (
    @(posedge clk_sys_in)
    (!bus_a_transmit_block_in || bus_a_transmit_block_out)
      && (!bus_b_transmit_block_in || bus_b_transmit_block_out))
    else $error("pin did not block bus");
endmodule // mcr_master_config
`default_nettype wire

// *** design/mcr_pkg.sv ***
// Constants for the master configuration register block.
package mcr_pkg;
  localparam int unsigned MCR_DATA_W = 16;
  localparam int unsigned MCR_ADDR_W = 8;
  localparam logic [7:0] MCR_CFG1_OFFSET = 8'h00;
  localparam int unsigned MCR_BIT_BLOCK_A = 15;
  localparam int unsigned MCR_BIT_BLOCK_B = 14;
  localparam int unsigned MCR_PTR_LSB = 10;
  localparam logic [15:0] MCR_CFG1_RESET = 16'h0000;
  // Bits that hold state; 13 and 12 are always zero, 9..0 kept as plain storage
  localparam logic [15:0] MCR_CFG1_MASK = 16'hcfff;
  localparam logic [15:0] MCR_READ_UNMAPPED = 16'h0000;
endpackage

// *** design/mcr_block_or.sv ***
// Transmit block combiner for one bus.
`timescale 1ns/1ps
`default_nettype none
module mcr_block_or (
  input wire logic reg_bit_in,
  input wire logic pin_in,
  output logic block_out
);
  // Either source blocks the bus
  assign block_out = reg_bit_in | pin_in;
endmodule // mcr_block_or
`default_nettype wire

// *** tb/mcr_host_model.sv ***
// Host model driving register accesses.
`timescale 1ns/1ps
`default_nettype none
module mcr_host_model import mcr_pkg::*; (
  input wire logic clk_sys_in,
  output logic wr_en_out,
  output logic rd_en_out,
  output logic [MCR_ADDR_W-1:0] addr_out,
  output logic [MCR_DATA_W-1:0] wdata_out
);
  initial {wr_en_out, rd_en_out, addr_out, wdata_out} = '0;
  // One-cycle strobe; data flips once released
  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys_in);
    {wr_en_out, rd_en_out, addr_out, wdata_out} <= {w, ~w, a, d};
    @(posedge clk_sys_in);
    {wr_en_out, rd_en_out, addr_out, wdata_out} <= {2'b00, a, ~d};
  endtask
endmodule // mcr_host_model
`default_nettype wire

// *** tb/master_config_tx_inhibit_tb.sv ***
// Self-checking bench for the master configuration register.
`timescale 1ns/1ps
`default_nettype none
module master_config_tx_inhibit_tb;
  logic clk_sys_in = 1'b0, arst_n_in = 1'b1, mrst = 1'b0, rrst = 1'b0, pa = 1'b0, pb = 1'b0;
  logic wr, rd, ba, bb;
  logic [7:0] ad;
  logic [15:0] wd, rdat, cfg;
  logic [1:0] ptr;
  int err_count = 0, tests_run = 0;
  always #5 clk_sys_in = ~clk_sys_in;
  mcr_host_model host (.clk_sys_in, .wr_en_out(wr), .rd_en_out(rd), .addr_out(ad),
    .wdata_out(wd));
  mcr_master_config DUT (.clk_sys_in, .arst_n_in, .wr_en_in(wr), .rd_en_in(rd),
    .addr_in(ad), .wdata_in(wd), .monitor_soft_reset_in(mrst),
    .remote_terminal_soft_reset_in(rrst), .bus_a_transmit_block_in(pa),
    .bus_b_transmit_block_in(pb), .rdata_out(rdat), .config_out(cfg),
    .pointer_select_out(ptr), .bus_a_transmit_block_out(ba), .bus_b_transmit_block_out(bb));
  // Compare and count
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic report_and_stop();
    if (err_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Main sequence
  initial begin
    arst_n_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    arst_n_in <= 1'b1;
    #1 chk("cfg", cfg, 16'h0000);
    chk("ptr", {14'h0, ptr}, 16'h0000);
    host.acc(1'b1, 8'h00, 16'hffff);
    #1 chk("cfg", cfg, 16'hcfff);
    chk("ptr", {14'h0, ptr}, 16'h0003);
    chk("blk", {14'h0, ba, bb}, 16'h0003);
    @(posedge clk_sys_in) {mrst, rrst} <= 2'b11;
    host.acc(1'b0, 8'h00, 16'h0000);
    #1 chk("rd", rdat, 16'hcfff);
    host.acc(1'b1, 8'h00, 16'h0000);
    host.acc(1'b1, 8'h05, 16'hffff);
    {pa, pb} <= 2'b10;
    host.acc(1'b0, 8'h05, 16'h0000);
    #1 chk("unmap", rdat, 16'h0000);
    chk("cfg", cfg, 16'h0000);
    chk("blk", {14'h0, ba, bb}, 16'h0002);
    host.acc(1'b1, 8'h00, 16'h7c00);
    #1 chk("cfg", cfg, 16'h4c00);
    chk("blk", {14'h0, ba, bb}, 16'h0003);
    host.acc(1'b0, 8'h00, 16'h0000);
    #1 chk("rd", rdat, 16'h4c00);
    @(posedge clk_sys_in);
    arst_n_in <= 1'b0;
    {pa, pb} <= 2'b01;
    #1 chk("cfg", cfg, 16'h0000);
    chk("rd", rdat, 16'h0000);
    chk("ptr", {14'h0, ptr}, 16'h0000);
    chk("blk", {14'h0, ba, bb}, 16'h0001);
    repeat (2) @(posedge clk_sys_in);
    arst_n_in <= 1'b1;
    host.acc(1'b1, 8'h00, 16'h8000);
    #1 chk("cfg", cfg, 16'h8000);
    chk("blk", {14'h0, ba, bb}, 16'h0003);
    host.acc(1'b0, 8'h00, 16'h0000);
    #1 chk("rd", rdat, 16'h8000);
    report_and_stop();
  end
endmodule // master_config_tx_inhibit_tb
`default_nettype wire
